// [core/serial_transmitter.v]
// Transmit half of a serial port with its control/status registers.
// Register port: read data stands the cycle after the read strobe.
`include "serial_tx_defines.vh"

module serial_transmitter #(
  parameter BAUD_W = 12
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire       port_out,
  input  wire       ext_clk_in,
  input  wire       tx_complete_ack,
  output reg        txd,
  output reg        buffer_empty_irq,
  output reg        tx_complete_irq
);

  reg  [7:0]        a_q;
  reg  [7:0]        b_q;
  reg  [7:0]        c_q;
  reg  [BAUD_W-1:0] baud_q;
  reg  [7:0]        buf_q;
  reg               buf_b8_q;
  reg               buf_full_q;
  reg               active_q;
  reg               xclk_s1_q;
  reg               xclk_s2_q;
  reg               xclk_last_q;
  wire              bit_tick;
  wire              line;
  wire              busy;
  wire              done;
  reg  [3:0]        nbits;
  reg  [4:0]        ratio;
  reg               shift;
  wire              sync_mode = c_q[`C_SYNC];
  wire              wr_data   = wr && addr == `ADDR_DATA;
  wire              load = buf_full_q && !busy && active_q;
  wire              ext_edge;

  always @* begin
    case ({b_q[`B_SIZE2], c_q[2:1]})
      3'h0:    nbits = 4'h5;
      3'h1:    nbits = 4'h6;
      3'h2:    nbits = 4'h7;
      3'h7:    nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
    if (sync_mode) ratio = `DIV_SYNC;
    else if (a_q[`A_U2X]) ratio = `DIV_DOUBLE;
    else ratio = `DIV_NORMAL;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xclk_s1_q   <= 1'b0;
      xclk_s2_q   <= 1'b0;
      xclk_last_q <= 1'b0;
    end else begin
      xclk_s1_q   <= ext_clk_in;
      xclk_s2_q   <= xclk_s1_q;
      xclk_last_q <= xclk_s2_q;
    end
  end

  // rising edge when polarity zero, falling otherwise
  assign ext_edge = c_q[`C_POL] ? (xclk_last_q && !xclk_s2_q)
                                : (!xclk_last_q && xclk_s2_q);

  always @* begin
    shift = sync_mode ? ext_edge : bit_tick;
  end

  baud_divider #(
    .W (BAUD_W)
  ) u_baud (
    .clk      (clk),
    .resetn   (resetn),
    .divisor  (baud_q),
    .reload   (wr && addr == `ADDR_BAUD_LOW),
    .ratio    (ratio),
    .bit_tick (bit_tick)
  );

  frame_shifter u_shift (
    .clk     (clk),
    .resetn  (resetn),
    .load    (load),
    .data    ({buf_b8_q, buf_q}),
    .nbits   (nbits),
    .par_en  (c_q[`C_PAR_EN]),
    .par_odd (c_q[`C_PAR_ODD]),
    .stop2   (c_q[`C_STOP2]),
    .shift   (shift),
    .line    (line),
    .busy    (busy),
    .done    (done)
  );

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_q        <= `RST_A;
      b_q        <= `RST_B;
      c_q        <= `RST_C;
      baud_q     <= `RST_BAUD;
      buf_q      <= 8'h00;
      buf_b8_q   <= 1'b0;
      buf_full_q <= 1'b0;
      active_q   <= 1'b0;
    end else begin
      if (wr && addr == `ADDR_STATUS_A) begin
        a_q[`A_U2X] <= wdata[`A_U2X];
      end
      if (wr && addr == `ADDR_STATUS_B) begin
        b_q <= wdata;
      end
      // select bit picks control C over high baud byte
      if (wr && addr == `ADDR_CTRL_C) begin
        if (wdata[`C_SEL]) begin
          c_q <= wdata;
        end else begin
          baud_q[BAUD_W-1:8] <= wdata[BAUD_W-9:0];
        end
      end
      if (wr && addr == `ADDR_BAUD_LOW) begin
        baud_q[7:0] <= wdata;
      end
      // data write loads buffer, latch ninth bit
      if (wr_data) begin
        buf_q      <= wdata;
        buf_b8_q   <= b_q[`B_TX_NINTH_BIT];
        buf_full_q <= 1'b1;
      end else if (load) begin
        buf_full_q <= 1'b0;
      end
      a_q[`A_TX_BUFFER_EMPTY_FLAG] <= !(wr_data || (buf_full_q && !load));
      if (done && !buf_full_q) begin
        a_q[`A_TXC] <= 1'b1;
      end else if (tx_complete_ack ||
                   (wr && addr == `ADDR_STATUS_A && wdata[`A_TXC])) begin
        a_q[`A_TXC] <= 1'b0;
      end
      // disable waits for shifter and buffer
      if (b_q[`B_TX_ENABLE_BIT]) begin
        active_q <= 1'b1;
      end else if (!busy && !buf_full_q && !wr_data) begin
        active_q <= 1'b0;
      end
    end
  end

  // Outputs registered; pin ownership follows active state
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata            <= 8'h00;
      txd              <= 1'b1;
      buffer_empty_irq <= 1'b0;
      tx_complete_irq  <= 1'b0;
    end else begin
      txd <= active_q ? line : port_out;
      buffer_empty_irq <= b_q[`B_TX_BUFFER_EMPTY_IRQ_ENABLE] && a_q[`A_TX_BUFFER_EMPTY_FLAG];
      tx_complete_irq  <= b_q[`B_TX_COMPLETE_IRQ_ENABLE] && a_q[`A_TXC] && !tx_complete_ack;
      rdata <= 8'h00;
      if (rd) begin
        if (addr == `ADDR_STATUS_A) rdata <= a_q;
        else if (addr == `ADDR_STATUS_B) rdata <= b_q;
        else if (addr == `ADDR_CTRL_C) rdata <= c_q;
        else if (addr == `ADDR_BAUD_LOW) rdata <= baud_q[7:0];
        else if (addr == `ADDR_ACK) rdata <= {7'h00, busy};
      end
    end
  end

endmodule

// [core/serial_tx_defines.vh]
// Constants for the serial transmitter: register offsets, fields, resets.
// Included by every design file of the transmitter.
`ifndef SERIAL_TX_DEFINES_VH
`define SERIAL_TX_DEFINES_VH

// Register offsets on the plain register port
`define ADDR_DATA        3'h0
`define ADDR_STATUS_A    3'h1
`define ADDR_STATUS_B    3'h2
`define ADDR_CTRL_C      3'h3
`define ADDR_BAUD_LOW    3'h4
`define ADDR_ACK         3'h5

// status_ctrl_a fields
`define A_TXC            6
`define A_TX_BUFFER_EMPTY_FLAG           5
`define A_U2X            1
// status_ctrl_b fields
`define B_TX_BUFFER_EMPTY_IRQ_ENABLE          5
`define B_TX_COMPLETE_IRQ_ENABLE          6
`define B_TX_ENABLE_BIT           3
`define B_SIZE2          2
`define B_TX_NINTH_BIT           0
// status_ctrl_c fields (select bit 7 picks it over the high baud byte)
`define C_SEL            7
`define C_SYNC           6
`define C_PAR_EN         5
`define C_PAR_ODD        4
`define C_STOP2          3
`define C_SIZE_LO        1
`define C_POL            0

// Reset values
`define RST_A            8'h20
`define RST_B            8'h00
`define RST_C            8'h06
`define RST_BAUD         12'h000

// Oversampling ratios of the bit clock
`define DIV_NORMAL       5'h10
`define DIV_DOUBLE       5'h08
`define DIV_SYNC         5'h02

`endif

// [core/baud_divider.v]
// Baud generator: down counter giving a one-cycle tick every div+1 clocks,
// then a second divider giving the bit-rate enable.
// Assumes a single clock; reloads whenever the low divisor byte is written.
`include "serial_tx_defines.vh"

module baud_divider #(
  parameter W = 12
) (
  input  wire         clk,
  input  wire         resetn,
  input  wire [W-1:0] divisor,
  input  wire         reload,
  input  wire [4:0]   ratio,
  output reg          bit_tick
);

  reg [W-1:0] count_q;
  reg [4:0]   sub_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q  <= {W{1'b0}};
      sub_q    <= 5'h00;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (reload) begin
        count_q <= divisor;
        sub_q   <= 5'h00;
      end else if (count_q == {W{1'b0}}) begin
        count_q <= divisor;
        if (sub_q >= ratio - 5'h01) begin
          sub_q    <= 5'h00;
          bit_tick <= 1'b1;
        end else begin
          sub_q <= sub_q + 5'h01;
        end
      end else begin
        count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// [core/frame_shifter.v]
// Frame shift register: start, 5..9 data bits LSB first, parity, 1-2 stops.
// Advances one bit per shift pulse; load only when idle or at frame end.
`include "serial_tx_defines.vh"

module frame_shifter (
  input  wire       clk,
  input  wire       resetn,
  input  wire       load,
  input  wire [8:0] data,
  input  wire [3:0] nbits,
  input  wire       par_en,
  input  wire       par_odd,
  input  wire       stop2,
  input  wire       shift,
  output reg        line,
  output reg        busy,
  output reg        done
);

  reg [12:0] sr_q;
  reg [12:0] frame;
  reg [3:0]  left_q;
  reg [8:0]  masked;
  reg        par;
  reg [3:0]  total;
  integer    i;

  always @* begin
    masked = 9'h000;
    for (i = 0; i < 9; i = i + 1) begin
      if (i < nbits) masked[i] = data[i];
    end
    par   = (^masked) ^ par_odd;
    total = nbits + {3'h0, par_en} + {3'h0, stop2} + 4'h1;
    // Start bit at the bottom, stop bits fill everything above
    frame    = {13{1'b1}};
    frame[0] = 1'b0;
    for (i = 0; i < 9; i = i + 1) begin
      if (i < nbits) frame[i+1] = data[i];
    end
    if (par_en) frame[nbits + 4'h1] = par;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sr_q   <= 13'h1fff;
      left_q <= 4'h0;
      line   <= 1'b1;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        // Right after a frame end the start bit goes out at once; from idle
        // it waits for the next bit pulse so that it lasts a whole bit
        if (done) begin
          line   <= 1'b0;
          sr_q   <= {1'b1, frame[12:1]};
          left_q <= total;
        end else begin
          sr_q   <= frame;
          left_q <= total + 4'h1;
        end
        busy   <= 1'b1;
      end else if (busy && shift) begin
        if (left_q == 4'h0) begin
          line <= 1'b1;
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          line   <= sr_q[0];
          sr_q   <= {1'b1, sr_q[12:1]};
          left_q <= left_q - 4'h1;
        end
      end
    end
  end

endmodule

// [sim/serial_transmitter_props.sv]
// Port checker for the serial transmitter, bound into it.
// Assumes every bit lasts two clocks or more, as any legal rate gives.
`include "serial_tx_defines.vh"
module serial_transmitter_props (
  input logic       clk,
  input logic       resetn,
  input logic [2:0] addr,
  input logic [7:0] wdata,
  input logic       wr,
  input logic       rd,
  input logic [7:0] rdata,
  input logic       port_out,
  input logic       ext_clk_in,
  input logic       tx_complete_ack,
  input logic       txd,
  input logic       buffer_empty_irq,
  input logic       tx_complete_irq
);
  logic en_q, seen_q, full_q, wr_q;
  wire  wr_a = wr && addr == `ADDR_STATUS_A;
  wire  wr_b = wr && addr == `ADDR_STATUS_B;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_q <= 1'b0;
      seen_q <= 1'b0;
      full_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      wr_q <= wr_q | wr;
      if (wr_b) en_q <= wdata[`B_TX_ENABLE_BIT];
      if (wr_b && wdata[`B_TX_ENABLE_BIT]) seen_q <= 1'b1;
      if (wr && addr == `ADDR_DATA && !seen_q) full_q <= 1'b1;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  reset_state_a: assert property (
    rd && addr == `ADDR_STATUS_A && !wr_q |=> rdata == `RST_A)
    else $error("status A off its reset value");
  held_data_a: assert property (
    rd && addr == `ADDR_STATUS_A && full_q && !seen_q |=> !rdata[`A_TX_BUFFER_EMPTY_FLAG])
    else $error("empty flag set with data held");
  port_follow_a: assert property (
    $past(resetn) && !seen_q |-> txd == $past(port_out))
    else $error("pin not following port level");
  bit_hold_a: assert property (
    en_q && $past(en_q) && $changed(txd) |=> $stable(txd))
    else $error("bit shorter than two clocks");
  ack_clear_a: assert property (
    tx_complete_ack |-> ##2 !tx_complete_irq)
    else $error("complete request survived service");
  write_one_a: assert property (
    wr_a && wdata[`A_TXC] |-> ##2 !tx_complete_irq)
    else $error("complete request survived write of one");
  empty_gate_a: assert property (
    wr_b && !wdata[`B_TX_BUFFER_EMPTY_IRQ_ENABLE] |-> ##2 !buffer_empty_irq)
    else $error("empty request while disabled");
  complete_gate_a: assert property (
    wr_b && !wdata[`B_TX_COMPLETE_IRQ_ENABLE] |-> ##2 !tx_complete_irq)
    else $error("complete request while disabled");
endmodule
bind serial_transmitter serial_transmitter_props i_props (.*);

// [sim/serial_line_receiver.sv]
// Far-end receiver on the transmit pin; samples each bit mid-period.
// Bit length, data count and parity presence are set by the bench.
module serial_line_receiver (
  input  logic       clk,
  input  logic       txd,
  input  int         bit_len,
  input  int         nbits,
  input  logic       par_on,
  output logic [8:0] word,
  output logic       par,
  output logic       stop,
  output int         count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] w;
  initial begin
    count = 0;
    forever begin
      @(negedge txd);
      repeat (bit_len / 2) @(posedge clk);
      // Short low pulses are not frames
      if (txd === 1'b0) begin
        w = '0;
        for (int i = 0; i < nbits + par_on + 1; i++) begin
          repeat (bit_len) @(posedge clk);
          if (i < nbits) w[i] = txd;
          else if (i == nbits && par_on) par = txd;
          else stop = txd;
        end
        word = w;
        count++;
      end
    end
  end
endmodule

// [sim/test_serial_transmitter.sv]
// Testbench for the serial transmitter: register tasks and frame checks.
// Assumes the line receiver model and the bound port checker.
`include "serial_tx_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD %0t: %h vs %h", $time, g, e); end end
module test_serial_transmitter;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, resetn = 0, wr = 0, rd = 0, ack = 0, ext = 0;
  logic       port_out = 1, par_on = 0, run_ext = 0;
  logic [2:0] addr = 0;
  logic [7:0] wdata = 0, rdata, c;
  logic [8:0] rx_word, exp;
  logic       txd, e_irq, c_irq, rx_par, rx_stop;
  int         fail_count = 0, comparisons = 0, bit_len = 16, nbits = 8;
  int         rx_count, n;
  logic [7:0] cfg [6] = '{8'h00, 8'h30, 8'h5c, 8'h72, 8'hf8, 8'h61};
  logic [8:0] dat [6] = '{9'h0ff, 9'h02d, 9'h0d6, 9'h081, 9'h15a, 9'h0c3};
  serial_transmitter i_dut (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port_out(port_out),
    .ext_clk_in(ext), .tx_complete_ack(ack), .txd(txd),
    .buffer_empty_irq(e_irq), .tx_complete_irq(c_irq));
  serial_line_receiver i_rx (.clk(clk), .txd(txd), .bit_len(bit_len),
    .nbits(nbits), .par_on(par_on), .word(rx_word), .par(rx_par),
    .stop(rx_stop), .count(rx_count));
  initial forever #25 clk = ~clk;
  // External clock of eight system clocks, far below the sync limit
  always begin
    repeat (4) @(posedge clk);
    if (run_ext) ext <= ~ext;
  end
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] m, e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata & m, e)
  endtask
  task automatic irq_chk(input logic e, input logic f);
    @(posedge clk);
    @(negedge clk);
    `CHK(e_irq, e)
    `CHK(c_irq, f)
  endtask
  task automatic send(input logic [7:0] a, input logic [7:0] d);
    wr_reg(`ADDR_STATUS_A, a);
    wr_reg(`ADDR_DATA, d);
  endtask
  task automatic wait_rx(input int k);
    for (int i = 0; i < 5000 && rx_count < k; i++) @(posedge clk);
    if (rx_count < k) begin
      fail_count++;
      $display("BAD %0t: frame missing", $time);
      final_report();
    end
  endtask
  task automatic pin_chk();
    port_out <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(txd, 1'b0)
    @(posedge clk);
    port_out <= 1'b1;
    $display("pin test done");
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(`ADDR_STATUS_A, 8'hff, `RST_A);
    rd_chk(`ADDR_STATUS_B, 8'hff, `RST_B);
    rd_chk(3'h6, 8'hff, 8'h00);
    irq_chk(1'b0, 1'b0);
    pin_chk();
    wr_reg(`ADDR_CTRL_C, 8'h00);
    wr_reg(`ADDR_BAUD_LOW, 8'h00);
    wr_reg(`ADDR_DATA, 8'h3c);
    rd_chk(`ADDR_STATUS_A, 8'h60, 8'h00);
    wr_reg(`ADDR_STATUS_B, 8'h08);
    wait_rx(1);
    `CHK(rx_word, 9'h03c)
    for (int r = 0; r < 6; r++) begin
      c = cfg[r];
      nbits = c[7:5] == 3'h7 ? 9 : 5 + c[6:5];
      bit_len = c[1] | c[0] ? 8 : 16;
      par_on = c[4];
      run_ext = c[0];
      wr_reg(`ADDR_CTRL_C, {1'b1, c[0], c[4:2], c[6:5], 1'b0});
      wr_reg(`ADDR_STATUS_B, {4'h0, 1'b1, c[7], 1'b0, dat[r][8]});
      n = rx_count + 1;
      send({6'h10, c[1], 1'b0}, dat[r][7:0]);
      wait_rx(n);
      exp = dat[r] & ((9'h001 << nbits) - 9'h001);
      `CHK(rx_word, exp)
      if (par_on) `CHK(rx_par, ^exp ^ c[3])
      `CHK(rx_stop, 1'b1)
    end
    run_ext = 0;
    $display("format test done");
    nbits = 8;
    par_on = 0;
    bit_len = 16;
    wr_reg(`ADDR_CTRL_C, 8'h86);
    n = rx_count;
    send(8'h40, 8'h11);
    repeat (4) @(posedge clk);
    wr_reg(`ADDR_DATA, 8'h22);
    rd_chk(`ADDR_STATUS_A, 8'h60, 8'h00);
    wait_rx(n + 1);
    `CHK(rx_word, 9'h011)
    wait_rx(n + 2);
    `CHK(rx_word, 9'h022)
    repeat (16) @(posedge clk);
    rd_chk(`ADDR_STATUS_A, 8'h60, 8'h60);
    $display("buffer test done");
    wr_reg(`ADDR_STATUS_B, 8'h68);
    irq_chk(1'b1, 1'b1);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    irq_chk(1'b1, 1'b0);
    send(8'h40, 8'h99);
    wait_rx(n + 3);
    repeat (16) @(posedge clk);
    irq_chk(1'b1, 1'b1);
    wr_reg(`ADDR_STATUS_A, 8'h40);
    irq_chk(1'b1, 1'b0);
    wr_reg(`ADDR_STATUS_B, 8'h08);
    irq_chk(1'b0, 1'b0);
    $display("request test done");
    send(8'h40, 8'h5e);
    wr_reg(`ADDR_STATUS_B, 8'h00);
    wait_rx(n + 4);
    `CHK(rx_word, 9'h05e)
    repeat (16) @(posedge clk);
    pin_chk();
    final_report();
  end
endmodule
